// ---- stou_pkg.sv ----
// shared constants and types for the software trace output unit
package stou_pkg;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned STAGES = 8;
  localparam logic [3:0] STAGE_FULL = 4'h8;
  localparam logic [3:0] STAGE_MARK = 4'h7;
  localparam int unsigned PC_OUT_NS = 5182;
  localparam int unsigned TAG_OUT_NS = 1727;
  localparam int unsigned BLIND_NS = 10000;
  // longest times round down, least time rounds up
  localparam int unsigned PC_OUT_CYC = PC_OUT_NS * CLK_MHZ / 1000;
  localparam int unsigned TAG_OUT_CYC = TAG_OUT_NS * CLK_MHZ / 1000;
  localparam int unsigned BLIND_CYC = (BLIND_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TAG_W = 10;
  localparam int unsigned REG_W = 5;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HDR_W = 14;
  localparam int unsigned FRAME_W = HDR_W + 2 * WORD_W;
  localparam int unsigned LANES = 2;
  localparam logic [5:0] HDR_BEATS = 6'h07;
  localparam logic [5:0] WORD_BEATS = 6'h10;
  localparam logic [5:0] MAX_BEATS = 6'h27;

  typedef enum logic [1:0] {
    STOU_KIND_PC = 2'h0,
    STOU_KIND_TAG = 2'h1,
    STOU_KIND_REG = 2'h2,
    STOU_KIND_OVF = 2'h3
  } stou_kind_e;

  typedef struct packed {
    stou_kind_e kind;
    logic has_pc;
    logic [TAG_W-1:0] aux;
    logic [WORD_W-1:0] value;
    logic [WORD_W-1:0] pc;
  } stou_rec_s;
endpackage

// ---- stou_link_if.sv ----
// five-pin debug link between the trace unit and the emulator
interface stou_link_if;
  logic frame_sync;
  logic [1:0] frame_data;
  logic emu_present;
  logic run_permit;
  modport device (output frame_sync, output frame_data, input emu_present, input run_permit);
  modport emulator (input frame_sync, input frame_data, output emu_present, output run_permit);
endinterface

// ---- stou_device.sv ----
// trace unit inside the processor: record capture, eight-stage buffer, link sender
module stou_device (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // trace instruction issue from the pipeline
  input wire logic instr_valid,
  input stou_pkg::stou_kind_e instr_kind,
  input wire logic instr_with_pc,
  input wire logic [stou_pkg::TAG_W-1:0] tag_immediate_operand,
  input wire logic [stou_pkg::REG_W-1:0] first_traced_register,
  input wire logic [stou_pkg::REG_W-1:0] last_traced_register,
  input wire logic [stou_pkg::WORD_W-1:0] pc_value,
  // register file read port
  output logic [stou_pkg::REG_W-1:0] reg_addr,
  input wire logic [stou_pkg::WORD_W-1:0] reg_data,
  // core control
  input wire logic run_start,
  output logic instr_stall,
  output logic run_allowed,
  output logic trace_active,
  output logic break_blind,
  output logic services_blocked,
  // link
  stou_link_if.device link
);
  typedef enum logic [1:0] {CAP_IDLE = 2'b01, CAP_PUSH = 2'b10} stou_cap_e;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SEND = 3'b010, TX_GAP = 3'b100} stou_tx_e;

  logic [1:0] present_s_q;
  logic [1:0] permit_s_q;
  logic present;
  stou_cap_e cap_q, cap_d;
  logic [stou_pkg::REG_W-1:0] cur_q, cur_d, last_q, last_d;
  logic with_pc_q, with_pc_d;
  logic [stou_pkg::WORD_W-1:0] pc_q, pc_d;
  logic new_valid;
  stou_pkg::stou_rec_s new_rec;
  stou_pkg::stou_rec_s buf_q [stou_pkg::STAGES];
  logic [2:0] wr_q, wr_d, rd_q, rd_d;
  logic [3:0] cnt_q, cnt_d;
  logic push_en;
  logic pop;
  stou_pkg::stou_rec_s push_rec;
  stou_tx_e tx_q, tx_d;
  logic [stou_pkg::FRAME_W-1:0] sh_q, sh_d;
  logic [5:0] beats_q, beats_d;
  logic [5:0] slot_q, slot_d;
  logic sync_q, sync_d;
  logic [1:0] data_q, data_d;
  logic [7:0] blind_q, blind_d;

  // pin inputs pass two flops before use
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      present_s_q <= 2'h0;
      permit_s_q <= 2'h0;
    end else begin
      present_s_q <= {present_s_q[0], link.emu_present};
      permit_s_q <= {permit_s_q[0], link.run_permit};
    end
  end
  assign present = present_s_q[1];
  assign trace_active = present;
  assign services_blocked = present;
  assign run_allowed = permit_s_q[1] | ~present;

  // capture: records only come from trace instructions, no event matching
  always_comb begin
    cap_d = cap_q;
    cur_d = cur_q;
    last_d = last_q;
    with_pc_d = with_pc_q;
    pc_d = pc_q;
    new_valid = 1'b0;
    new_rec = '0;
    new_rec.pc = pc_value;
    new_rec.has_pc = instr_with_pc;
    unique case (cap_q)
      CAP_IDLE: begin
        if (instr_valid) begin
          unique case (instr_kind)
            stou_pkg::STOU_KIND_PC: begin
              new_valid = 1'b1;
              new_rec.kind = stou_pkg::STOU_KIND_PC;
              new_rec.has_pc = 1'b0;
              new_rec.value = pc_value;
            end
            stou_pkg::STOU_KIND_TAG: begin
              new_valid = 1'b1;
              new_rec.kind = stou_pkg::STOU_KIND_TAG;
              new_rec.aux = tag_immediate_operand;
            end
            stou_pkg::STOU_KIND_REG: begin
              if (first_traced_register <= last_traced_register) begin
                cap_d = CAP_PUSH;
                cur_d = first_traced_register;
                last_d = last_traced_register;
                with_pc_d = instr_with_pc;
                pc_d = pc_value;
              end
            end
            default: ;
          endcase
        end
      end
      CAP_PUSH: begin
        // one register per cycle, lowest number first
        new_valid = 1'b1;
        new_rec.kind = stou_pkg::STOU_KIND_REG;
        new_rec.has_pc = with_pc_q;
        new_rec.pc = pc_q;
        new_rec.aux = {{(stou_pkg::TAG_W - stou_pkg::REG_W){1'b0}}, cur_q};
        new_rec.value = reg_data;
        cur_d = cur_q + 5'h01;
        if (cur_q == last_q) cap_d = CAP_IDLE;
      end
    endcase
  end
  assign reg_addr = cur_q;
  assign instr_stall = (cap_q == CAP_PUSH);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_q <= CAP_IDLE;
      cur_q <= '0;
      last_q <= '0;
      with_pc_q <= 1'b0;
      pc_q <= '0;
    end else begin
      cap_q <= cap_d;
      cur_q <= cur_d;
      last_q <= last_d;
      with_pc_q <= with_pc_d;
      pc_q <= pc_d;
    end
  end

  // buffer admission: seven records, then one marker, then drops
  always_comb begin
    push_en = 1'b0;
    push_rec = new_rec;
    if (new_valid && present) begin
      if (cnt_q < stou_pkg::STAGE_MARK) begin
        push_en = 1'b1;
      end else if (cnt_q == stou_pkg::STAGE_MARK) begin
        push_en = 1'b1;
        push_rec = '0;
        push_rec.kind = stou_pkg::STOU_KIND_OVF;
      end
    end
    pop = (tx_q == TX_IDLE) && (cnt_q != 4'h0);
    wr_d = push_en ? wr_q + 3'h1 : wr_q;
    rd_d = pop ? rd_q + 3'h1 : rd_q;
    cnt_d = cnt_q + {3'h0, push_en} - {3'h0, pop};
  end

  // the marker is admitted on the count before this cycle's pop, so a slot can be wasted under load
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // buffer storage, no reset needed on the data
  always_ff @(posedge ref_clk) begin
    if (push_en) buf_q[wr_q] <= push_rec;
  end

  // sender: header, then value, then pc, two bits a beat, msb first
  always_comb begin
    stou_pkg::stou_rec_s head;
    head = buf_q[rd_q];
    tx_d = tx_q;
    sh_d = sh_q;
    beats_d = beats_q;
    slot_d = slot_q;
    sync_d = 1'b0;
    data_d = 2'h0;
    unique case (tx_q)
      TX_IDLE: begin
        if (pop) begin
          tx_d = TX_SEND;
          beats_d = stou_pkg::HDR_BEATS;
          slot_d = 6'(stou_pkg::PC_OUT_CYC);
          if (head.kind == stou_pkg::STOU_KIND_TAG) begin
            sh_d = {head.kind, head.has_pc, head.aux, 1'b0, head.pc, {stou_pkg::WORD_W{1'b0}}};
            if (head.has_pc) beats_d = stou_pkg::HDR_BEATS + stou_pkg::WORD_BEATS;
            else slot_d = 6'(stou_pkg::TAG_OUT_CYC);
          end else begin
            sh_d = {head.kind, head.has_pc, head.aux, 1'b0, head.value, head.pc};
            if (head.kind != stou_pkg::STOU_KIND_OVF) begin
              beats_d = stou_pkg::HDR_BEATS + stou_pkg::WORD_BEATS;
              if (head.has_pc) beats_d = stou_pkg::MAX_BEATS;
            end else slot_d = 6'(stou_pkg::TAG_OUT_CYC);
          end
        end
      end
      TX_SEND: begin
        sync_d = 1'b1;
        data_d = sh_q[stou_pkg::FRAME_W-1 -: stou_pkg::LANES];
        sh_d = sh_q << stou_pkg::LANES;
        beats_d = beats_q - 6'h01;
        slot_d = slot_q - 6'h01;
        if (beats_q == 6'h01) tx_d = TX_GAP;
      end
      TX_GAP: begin
        // pace records to the documented output interval
        slot_d = slot_q - 6'h01;
        if (slot_q <= 6'h01) tx_d = TX_IDLE;
      end
      default: tx_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= TX_IDLE;
      sh_q <= '0;
      beats_q <= '0;
      slot_q <= '0;
      sync_q <= 1'b0;
      data_q <= 2'h0;
    end else begin
      tx_q <= tx_d;
      sh_q <= sh_d;
      beats_q <= beats_d;
      slot_q <= slot_d;
      sync_q <= sync_d;
      data_q <= data_d;
    end
  end
  assign link.frame_sync = sync_q & present;
  assign link.frame_data = present ? data_q : 2'h0;

  // break blind window after start when not tracing
  always_comb begin
    blind_d = blind_q;
    if (run_start && !present) blind_d = 8'(stou_pkg::BLIND_CYC);
    else if (blind_q != 8'h00) blind_d = blind_q - 8'h01;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) blind_q <= 8'h00;
    else blind_q <= blind_d;
  end
  assign break_blind = (blind_q != 8'h00);
endmodule // stou_device

// ---- stou_emulator.sv ----
// emulator end: link receiver and timestamp counter
module stou_emulator (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // session control
  input wire logic connect,
  input wire logic svc_req,
  output logic svc_refused,
  // received records
  output logic rec_valid,
  output stou_pkg::stou_rec_s rec,
  output logic [stou_pkg::WORD_W-1:0] rec_stamp,
  // link
  stou_link_if.emulator link
);
  logic [1:0] sync_s_q;
  logic [3:0] data_s_q;
  logic [stou_pkg::FRAME_W-1:0] sh_q, sh_d;
  logic [5:0] beats_q, beats_d;
  logic [stou_pkg::WORD_W-1:0] stamp_q, stamp_d;
  logic counting_q, counting_d;
  logic permit_q, permit_d;
  logic valid_q, valid_d;
  stou_pkg::stou_rec_s rec_q, rec_d;
  logic [stou_pkg::WORD_W-1:0] rstamp_q, rstamp_d;
  logic [stou_pkg::FRAME_W-1:0] aligned;

  // link pins pass two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_s_q <= 2'h0;
      data_s_q <= 4'h0;
    end else begin
      sync_s_q <= {sync_s_q[0], link.frame_sync};
      data_s_q <= {data_s_q[1:0], link.frame_data};
    end
  end

  // receive beats, decode at end of frame, stamp at receipt
  always_comb begin
    sh_d = sh_q;
    beats_d = beats_q;
    valid_d = 1'b0;
    rec_d = rec_q;
    rstamp_d = rstamp_q;
    aligned = sh_q << (stou_pkg::LANES * (stou_pkg::MAX_BEATS - beats_q));
    if (sync_s_q[1]) begin
      sh_d = {sh_q[stou_pkg::FRAME_W-3:0], data_s_q[3:2]};
      beats_d = beats_q + 6'h01;
    end else if (beats_q != 6'h00) begin
      beats_d = 6'h00;
      valid_d = 1'b1;
      rstamp_d = stamp_q;
      rec_d = '0;
      rec_d.kind = stou_pkg::stou_kind_e'(aligned[stou_pkg::FRAME_W-1 -: 2]);
      rec_d.has_pc = aligned[stou_pkg::FRAME_W-3];
      rec_d.aux = aligned[stou_pkg::FRAME_W-4 -: stou_pkg::TAG_W];
      if (rec_d.kind == stou_pkg::STOU_KIND_TAG) begin
        if (rec_d.has_pc) rec_d.pc = aligned[2*stou_pkg::WORD_W-1 -: stou_pkg::WORD_W];
      end else if (rec_d.kind != stou_pkg::STOU_KIND_OVF) begin
        rec_d.value = aligned[2*stou_pkg::WORD_W-1 -: stou_pkg::WORD_W];
        if (rec_d.has_pc) rec_d.pc = aligned[stou_pkg::WORD_W-1:0];
      end
    end
  end

  // counter first, permission to run one cycle later
  always_comb begin
    counting_d = connect;
    stamp_d = connect ? (counting_q ? stamp_q + 32'h1 : 32'h0) : stamp_q;
    permit_d = connect & counting_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_q <= '0;
      beats_q <= '0;
      stamp_q <= '0;
      counting_q <= 1'b0;
      permit_q <= 1'b0;
      valid_q <= 1'b0;
      rec_q <= '0;
      rstamp_q <= '0;
    end else begin
      sh_q <= sh_d;
      beats_q <= beats_d;
      stamp_q <= stamp_d;
      counting_q <= counting_d;
      permit_q <= permit_d;
      valid_q <= valid_d;
      rec_q <= rec_d;
      rstamp_q <= rstamp_d;
    end
  end

  assign link.emu_present = connect;
  assign link.run_permit = permit_q;
  assign svc_refused = svc_req & connect;
  assign rec_valid = valid_q;
  assign rec = rec_q;
  assign rec_stamp = rstamp_q;
endmodule // stou_emulator

// ---- stou_link_sva.sv ----
// link-level assertions watching the interface between device and emulator ends
module stou_link_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link signals
  input wire logic frame_sync,
  input wire logic [1:0] frame_data,
  input wire logic emu_present,
  input wire logic run_permit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] len_q;
  logic [1:0] kind_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // beats seen so far in the frame and the kind from its first beat
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      len_q <= 6'h00;
      kind_q <= 2'h0;
    end else begin
      len_q <= frame_sync ? len_q + 6'h01 : 6'h00;
      kind_q <= (frame_sync && len_q == 6'h00) ? frame_data : kind_q;
    end
  end

  // presence passes two sync flops, so allow those before the link must be quiet
  a_quiet_when_unplugged: assert property (!emu_present [*3] |-> !frame_sync)
    else $error("frame driven with no emulator");
  a_frame_not_long: assert property (frame_sync |-> len_q < 6'h27)
    else $error("frame longer than one record");
  a_marker_header_only: assert property (frame_sync && len_q == 6'h00 && frame_data == 2'h3 |-> frame_sync [*7] ##1 !frame_sync)
    else $error("overflow marker frame not header only");
  a_pc_frame_len: assert property ($fell(frame_sync) && kind_q == 2'h0 |-> len_q == 6'h17)
    else $error("pc frame length wrong");
  a_tag_frame_len: assert property ($fell(frame_sync) && kind_q == 2'h1 |-> len_q == 6'h07 || len_q == 6'h17)
    else $error("tag frame length wrong");
  a_reg_frame_len: assert property ($fell(frame_sync) && kind_q == 2'h2 |-> len_q == 6'h17 || len_q == 6'h27)
    else $error("register frame length wrong");
  a_frame_gap_min: assert property ($fell(frame_sync) |-> !frame_sync [*8])
    else $error("frames too close together");
  a_permit_after_count: assert property ($rose(emu_present) |-> !run_permit)
    else $error("run permitted with connect");
  a_permit_needs_emu: assert property (run_permit |-> emu_present)
    else $error("run permitted without emulator");

  // main traffic shapes
  c_marker_frame: cover property (frame_sync && len_q == 6'h00 && frame_data == 2'h3);
  c_long_frame: cover property ($fell(frame_sync) && len_q == 6'h27);
  c_run_permit: cover property ($rose(run_permit));
endmodule // stou_link_sva

// ---- test_software_trace_output_unit.sv ----
// self-checking bench joining device and emulator ends over the debug link
module test_software_trace_output_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b1;
  logic instr_valid = 1'b0;
  stou_pkg::stou_kind_e instr_kind = stou_pkg::STOU_KIND_PC;
  logic instr_with_pc = 1'b0;
  logic [9:0] tag_immediate_operand = 10'h000;
  logic [4:0] first_traced_register = 5'h00;
  logic [4:0] last_traced_register = 5'h00;
  logic [31:0] pc_value = 32'h0;
  logic [4:0] reg_addr;
  logic [31:0] reg_data;
  logic run_start = 1'b0;
  logic instr_stall, run_allowed, trace_active, break_blind, services_blocked;
  logic connect = 1'b0;
  logic svc_req = 1'b0;
  logic svc_refused, rec_valid;
  stou_pkg::stou_rec_s rec;
  logic [31:0] rec_stamp;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  stou_pkg::stou_rec_s got_q[$];
  logic [31:0] stamp_q[$];

  stou_link_if link_if ();
  stou_device stou_device_i (.ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_kind(instr_kind), .instr_with_pc(instr_with_pc), .tag_immediate_operand(tag_immediate_operand),
    .first_traced_register(first_traced_register), .last_traced_register(last_traced_register),
    .pc_value(pc_value), .reg_addr(reg_addr), .reg_data(reg_data), .run_start(run_start),
    .instr_stall(instr_stall), .run_allowed(run_allowed), .trace_active(trace_active),
    .break_blind(break_blind), .services_blocked(services_blocked), .link(link_if));
  stou_emulator stou_emulator_i (.ref_clk(ref_clk), .reset_n(reset_n), .connect(connect), .svc_req(svc_req),
    .svc_refused(svc_refused), .rec_valid(rec_valid), .rec(rec), .rec_stamp(rec_stamp), .link(link_if));
  stou_link_sva stou_link_sva_i (.ref_clk(ref_clk), .reset_n(reset_n), .frame_sync(link_if.frame_sync),
    .frame_data(link_if.frame_data), .emu_present(link_if.emu_present), .run_permit(link_if.run_permit));

  // register file model: the register number sits in the low bits
  assign reg_data = {27'h2d2d2d2, reg_addr};

  always #50 ref_clk = ~ref_clk;

  // collect records at the falling edge where the pulse has settled; cut a hang short
  always @(negedge ref_clk) begin
    cycles++;
    if (rec_valid === 1'b1) begin
      got_q.push_back(rec);
      stamp_q.push_back(rec_stamp);
    end
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task end_of_test();
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // valid stays up so back-to-back issues never assign it twice in one step
  task issue(input stou_pkg::stou_kind_e k, input logic wp, input logic [9:0] t, input logic [4:0] f,
             input logic [4:0] l, input logic [31:0] pc);
    instr_valid = 1'b1;
    instr_kind = k;
    instr_with_pc = wp;
    tag_immediate_operand = t;
    first_traced_register = f;
    last_traced_register = l;
    pc_value = pc;
    @(negedge ref_clk);
  endtask

  task wait_recs(input int n);
    for (int i = 0; i < 3000 && got_q.size() < n; i++) @(negedge ref_clk);
    check("record count", 32'(got_q.size()), 32'(n));
  endtask

  task chk_rec(input int i, input stou_pkg::stou_kind_e k, input logic hp, input logic [9:0] aux);
    check("rec kind", {30'h0, got_q[i].kind}, {30'h0, k});
    check("rec has_pc", 32'(got_q[i].has_pc), 32'(hp));
    check("rec aux", {22'h0, got_q[i].aux}, {22'h0, aux});
  endtask

  task s_unplugged();
    issue(stou_pkg::STOU_KIND_TAG, 1'b0, 10'h155, 5'h00, 5'h00, 32'h0);
    instr_valid = 1'b0;
    run_start = 1'b1;
    @(negedge ref_clk);
    run_start = 1'b0;
    repeat (50) @(negedge ref_clk);
    check("blind early", 32'(break_blind), 32'h1);
    check("trace idle", 32'(trace_active), 32'h0);
    check("run free", 32'(run_allowed), 32'h1);
    // window opened at the edge before the pulse dropped: last blind cycle is the hundredth
    repeat (stou_pkg::BLIND_CYC - 51) @(negedge ref_clk);
    check("blind last", 32'(break_blind), 32'h1);
    @(negedge ref_clk);
    check("blind over", 32'(break_blind), 32'h0);
    check("no record", 32'(got_q.size()), 32'h0);
  endtask

  task s_session();
    connect = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("run held", 32'(run_allowed), 32'h0);
    repeat (2) @(negedge ref_clk);
    check("run permit", 32'(link_if.run_permit), 32'h1);
    check("run allowed", 32'(run_allowed), 32'h1);
    check("trace on", 32'(trace_active), 32'h1);
    check("svc blocked", 32'(services_blocked), 32'h1);
    svc_req = 1'b1;
    run_start = 1'b1;
    @(negedge ref_clk);
    check("svc refused", 32'(svc_refused), 32'h1);
    svc_req = 1'b0;
    run_start = 1'b0;
    repeat (20) @(negedge ref_clk);
    check("no blind tracing", 32'(break_blind), 32'h0);
  endtask

  // back-to-back issues, with the unused kind code in the middle
  task s_kinds();
    issue(stou_pkg::STOU_KIND_PC, 1'b0, 10'h000, 5'h00, 5'h00, 32'h00001000);
    issue(stou_pkg::STOU_KIND_OVF, 1'b0, 10'h3ff, 5'h00, 5'h00, 32'h00001002);
    issue(stou_pkg::STOU_KIND_TAG, 1'b0, 10'h2a5, 5'h00, 5'h00, 32'h00001004);
    issue(stou_pkg::STOU_KIND_TAG, 1'b1, 10'h15a, 5'h00, 5'h00, 32'h00001008);
    instr_valid = 1'b0;
    wait_recs(3);
    chk_rec(0, stou_pkg::STOU_KIND_PC, 1'b0, 10'h000);
    check("pc value", got_q[0].value, 32'h00001000);
    chk_rec(1, stou_pkg::STOU_KIND_TAG, 1'b0, 10'h2a5);
    chk_rec(2, stou_pkg::STOU_KIND_TAG, 1'b1, 10'h15a);
    check("tag pc", got_q[2].pc, 32'h00001008);
    check("stamp at receipt", 32'(stamp_q[1] - stamp_q[0] >= 32'd17), 32'h1);
    got_q.delete();
    stamp_q.delete();
  endtask

  task s_push();
    // reversed bounds first: refused, must leave no record and no stall
    issue(stou_pkg::STOU_KIND_REG, 1'b1, 10'h000, 5'h06, 5'h03, 32'h00002000);
    issue(stou_pkg::STOU_KIND_REG, 1'b1, 10'h000, 5'h03, 5'h06, 32'h00002000);
    instr_valid = 1'b0;
    check("push stall", 32'(instr_stall), 32'h1);
    repeat (4) @(negedge ref_clk);
    check("stall done", 32'(instr_stall), 32'h0);
    wait_recs(4);
    for (int i = 0; i < 4; i++) begin
      chk_rec(i, stou_pkg::STOU_KIND_REG, 1'b1, 10'(i + 3));
      check("reg value", got_q[i].value, {27'h2d2d2d2, 5'(i + 3)});
      check("reg pc", got_q[i].pc, 32'h00002000);
    end
    got_q.delete();
    stamp_q.delete();
  endtask

  // ten registers at once, more than the program should ever push
  task s_overflow();
    int n;
    issue(stou_pkg::STOU_KIND_REG, 1'b0, 10'h000, 5'h00, 5'h09, 32'h00003000);
    instr_valid = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      if (got_q.size() > 0 && got_q[$].kind === stou_pkg::STOU_KIND_OVF) break;
      @(negedge ref_clk);
    end
    n = got_q.size();
    check("marker last", {30'h0, got_q[$].kind}, {30'h0, stou_pkg::STOU_KIND_OVF});
    check("kept before marker", 32'(n >= 8 && n <= 9), 32'h1);
    for (int i = 0; i < n - 1; i++) begin
      chk_rec(i, stou_pkg::STOU_KIND_REG, 1'b0, 10'(i));
    end
    repeat (200) @(negedge ref_clk);
    check("nothing after marker", 32'(got_q.size()), 32'(n));
  endtask

  // reset for five cycles, then the scenarios in turn
  initial begin
    // a real falling edge so the asynchronous resets act from time zero
    reset_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    s_unplugged();
    s_session();
    s_kinds();
    s_push();
    s_overflow();
    end_of_test();
  end
endmodule // test_software_trace_output_unit
